// ### core/bbse_pkg.sv
/*
 Constants and types for the branch and bit-set execution block.
 Assumes a four-phase instruction cycle driven by the surrounding core.
*/
// Functional notes
// - Not-zero branch loads PC+2+2n when the zero flag is clear.
// - Not-zero branch takes one cycle untaken, two taken; extra cycle idles.
// - Branch target is advanced PC plus twice the signed offset.
// - Unconditional branch has top five bits 11010 and an 11-bit signed offset.
// - Unconditional branch always loads target and takes two cycles.
// - Bit-set forces bit b of register f to one, others unchanged.
// - Bit-set decodes 1000, three bit bits, access bit, 8-bit address.
// - Access bit 0 selects the access bank, ignoring the bank select register.
// - Access bit 1 combines address with bank select register bank.
// - Bit-set completes in one cycle: decode, read, modify, write back.
package bbse_pkg;
   localparam int PC_W = 21;
   localparam int DADDR_W = 12;
   localparam logic [7:0] BNZ_TOP = 8'hE1;
   localparam logic [4:0] BRA_TOP = 5'h1A;
   localparam logic [3:0] BSF_TOP = 4'h8;
   localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
   localparam logic [PC_W-1:0] PC_RST = 21'h000000;
   localparam logic [7:0] ACCESS_SPLIT = 8'h80;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
   localparam logic [1:0] Q_RST = 2'h0;

   typedef enum logic [1:0] {
      BBSE_OP_NONE,
      BBSE_OP_BNZ,
      BBSE_OP_BRA,
      BBSE_OP_BSF
   } bbse_op_t;

   typedef enum {
      BBSE_ST_EXEC,
      BBSE_ST_NOP
   } bbse_state_t;
endpackage : bbse_pkg

// ### core/bbse_mem_if.sv
/*
 Data-memory access bundle between the decoder and the register file.
 Assumes one read and one write port, same clock.
*/
`timescale 1ns/1ps
interface bbse_mem_if #(
   parameter int AW = 12
);
   logic rd_en;
   logic wr_en;
   logic [AW-1:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport master (output rd_en, output wr_en, output addr, output wdata, input rdata);
   modport slave (input rd_en, input wr_en, input addr, input wdata, output rdata);
endinterface : bbse_mem_if

// ### core/bbse_ram.sv
/*
 Small data memory with registered read data.
 Assumes synchronous access within one instruction cycle.
*/
`timescale 1ns/1ps
module bbse_ram #(
   parameter int AW = 12
) (
   input wire logic core_clk_in,
   bbse_mem_if.slave mem
);
   logic [7:0] mem_ff [0:(1<<AW)-1];
   logic [7:0] rdata_ff;

   if (AW < 8 || AW > 16) begin : g_bad_aw
      $error("bbse_ram: AW out of range");
   end

   always_ff @(posedge core_clk_in) begin
      if (mem.wr_en) begin
         mem_ff[mem.addr] <= mem.wdata;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (mem.rd_en) begin
         rdata_ff <= mem_ff[mem.addr];
      end
   end

   assign mem.rdata = rdata_ff;
endmodule : bbse_ram

// ### core/bbse_seq.sv
/*
 Phase sequencer: free-running Q1..Q4 counter.
 Assumes one core clock per phase.
*/
`timescale 1ns/1ps
module bbse_seq (
   input wire logic core_clk_in,
   input wire logic rst_in,
   output logic [1:0] q_out,
   output logic q4_out
);
   logic [1:0] q_ff;

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         q_ff <= bbse_pkg::Q_RST;
      end else begin
         q_ff <= q_ff + 2'h1;
      end
   end

   assign q_out = q_ff;
   assign q4_out = (q_ff == 2'h3);
endmodule : bbse_seq

// ### core/bbse_top.sv
/*
 Decode and execution of not-zero branch, unconditional branch and bit-set.
 One instruction cycle is four clocks, phases Q1..Q4, counted by a free-running
 sequencer that starts at Q1 when reset is released.
 Branches: the offset is read in Q2, the target is formed in Q3, and
 pc_load_out pulses for one clock after the end of Q4 when the branch is taken.
 A taken branch then idles for one whole instruction cycle, during which new
 requests are refused and busy_out stays high.
 Bit-set: the addressed byte of the internal data memory is read in Q2, the bit
 is set in Q3 and the byte is written back at the end of Q4.
 No status flag is produced here; only the PC or the addressed byte changes.
 Assumes the core presents an instruction at Q1 of each instruction cycle,
 holds it while instr_req_in is sampled, and advances the PC by 2 per fetch.
 Assumes pc_in is the address of the offered instruction, and that the core
 takes pc_next_out into its PC whenever pc_load_out is high.
 Assumes the zero flag and bank select presented with the instruction are final.
 Assumes no other master writes the internal data memory.
*/
`timescale 1ns/1ps
module bbse_top #(
   parameter int PC_W = bbse_pkg::PC_W,
   parameter int DADDR_W = bbse_pkg::DADDR_W
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic instr_req_in,
   input wire logic [15:0] instr_in,
   input wire logic [PC_W-1:0] pc_in,
   input wire logic zero_flag_in,
   input wire logic [3:0] bank_select_register_in,
   output logic instr_ack_out,
   output logic busy_out,
   output logic pc_load_out,
   output logic [PC_W-1:0] pc_next_out,
   output logic [1:0] phase_out,
   output logic unknown_op_out
);
   // ==========================================================
   // Elaboration checks
   // ==========================================================
   if (PC_W != bbse_pkg::PC_W) begin : g_bad_pc_w
      $error("bbse_top: PC_W must match package");
   end
   if (DADDR_W != bbse_pkg::DADDR_W) begin : g_bad_daddr_w
      $error("bbse_top: DADDR_W must be 12");
   end

   // ==========================================================
   // Phase sequencer and memory
   // ==========================================================
   logic [1:0] q;
   logic q4;

   bbse_seq u_seq (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .q_out(q),
      .q4_out(q4)
   );

   // ==========================================================
   // Phase strobes
   // ==========================================================
   logic ph_decode;
   logic ph_read;
   logic ph_process;
   logic ph_write;
   assign ph_decode = (q == 2'h0);
   assign ph_read = (q == 2'h1);
   assign ph_process = (q == 2'h2);
   assign ph_write = q4;

   bbse_mem_if #(.AW(DADDR_W)) mem ();

   bbse_ram #(.AW(DADDR_W)) u_ram (
      .core_clk_in(core_clk_in),
      .mem(mem)
   );

   // ==========================================================
   // Decode helpers
   // ==========================================================
   function automatic bbse_pkg::bbse_op_t decode_op(input logic [15:0] ins);
      bbse_pkg::bbse_op_t op;
      op = bbse_pkg::BBSE_OP_NONE;
      if (ins[15:8] == bbse_pkg::BNZ_TOP) begin
         op = bbse_pkg::BBSE_OP_BNZ;
      end else if (ins[15:11] == bbse_pkg::BRA_TOP) begin
         op = bbse_pkg::BBSE_OP_BRA;
      end else if (ins[15:12] == bbse_pkg::BSF_TOP) begin
         op = bbse_pkg::BBSE_OP_BSF;
      end
      return op;
   endfunction : decode_op

   // Advanced PC plus twice the sign-extended offset
   function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] pc,
                                                   input logic [10:0] n);
      logic [PC_W-1:0] ext;
      ext = {{(PC_W-11){n[10]}}, n};
      return pc + bbse_pkg::PC_STEP + {ext[PC_W-2:0], 1'b0};
   endfunction : rel_target

   // Offset field of either branch, sign-extended to 11 bits
   function automatic logic [10:0] branch_offset(input bbse_pkg::bbse_op_t op,
                                                 input logic [15:0] ins);
      logic [10:0] n;
      n = ins[10:0];
      if (op == bbse_pkg::BBSE_OP_BNZ) begin
         n = {{3{ins[7]}}, ins[7:0]};
      end
      return n;
   endfunction : branch_offset

   function automatic logic branch_taken(input bbse_pkg::bbse_op_t op,
                                         input logic zero);
      return (op == bbse_pkg::BBSE_OP_BRA) ||
             ((op == bbse_pkg::BBSE_OP_BNZ) && !zero);
   endfunction : branch_taken

   function automatic logic [7:0] set_mask(input logic [2:0] b);
      return 8'h01 << b;
   endfunction : set_mask

   // Access bank: low half is bank 0, high half the top bank
   function automatic logic [DADDR_W-1:0] file_addr(input logic a,
                                                     input logic [7:0] f,
                                                     input logic [3:0] bank);
      logic [DADDR_W-1:0] addr;
      addr = {bank, f};
      if (!a) begin
         if (f < bbse_pkg::ACCESS_SPLIT) begin
            addr = {4'h0, f};
         end else begin
            addr = {bbse_pkg::ACCESS_HI_BANK, f};
         end
      end
      return addr;
   endfunction : file_addr

   // ==========================================================
   // Instruction latch at Q1
   // ==========================================================
   bbse_pkg::bbse_state_t state_ff;
   logic [15:0] ir_ff;
   bbse_pkg::bbse_op_t op_ff;
   logic [PC_W-1:0] pc_ff;
   logic zero_ff;
   logic [3:0] bank_ff;
   logic live_ff;
   logic [10:0] offs_ff;
   logic [PC_W-1:0] target_ff;
   logic taken_ff;
   logic [7:0] mod_ff;
   logic pc_load_ff;
   logic [PC_W-1:0] pc_next_ff;
   logic unknown_ff;

   logic take_in;
   assign take_in = instr_req_in && ph_decode && (state_ff == bbse_pkg::BBSE_ST_EXEC);
   assign instr_ack_out = take_in;
   assign busy_out = (state_ff == bbse_pkg::BBSE_ST_NOP) || live_ff;
   assign phase_out = q;

   // Q1: decode
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ir_ff <= 16'h0000;
         op_ff <= bbse_pkg::BBSE_OP_NONE;
      end else if (take_in) begin
         ir_ff <= instr_in;
         op_ff <= decode_op(instr_in);
      end
   end

   // Q1: context sampled with the instruction
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pc_ff <= bbse_pkg::PC_RST;
         zero_ff <= 1'b0;
         bank_ff <= 4'h0;
      end else if (take_in) begin
         pc_ff <= pc_in;
         zero_ff <= zero_flag_in;
         bank_ff <= bank_select_register_in;
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         live_ff <= 1'b0;
      end else if (take_in) begin
         live_ff <= 1'b1;
      end else if (q4) begin
         live_ff <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         unknown_ff <= 1'b0;
      end else if (take_in) begin
         unknown_ff <= (decode_op(instr_in) == bbse_pkg::BBSE_OP_NONE);
      end
   end
   assign unknown_op_out = unknown_ff;

   // ==========================================================
   // Branch path: Q2 read offset, Q3 process, Q4 write PC
   // ==========================================================
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         offs_ff <= 11'h000;
      end else if (live_ff && ph_read) begin
         offs_ff <= branch_offset(op_ff, ir_ff);
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         target_ff <= bbse_pkg::PC_RST;
      end else if (live_ff && ph_process) begin
         target_ff <= rel_target(pc_ff, offs_ff);
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         taken_ff <= 1'b0;
      end else if (live_ff && ph_process) begin
         taken_ff <= branch_taken(op_ff, zero_ff);
      end
   end

   // PC written at Q4 only when taken; one-clock load strobe
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pc_load_ff <= 1'b0;
      end else begin
         pc_load_ff <= live_ff && ph_write && taken_ff;
      end
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pc_next_ff <= bbse_pkg::PC_RST;
      end else if (live_ff && ph_write && taken_ff) begin
         pc_next_ff <= target_ff;
      end
   end
   assign pc_load_out = pc_load_ff;
   assign pc_next_out = pc_next_ff;

   // Taken branch inserts one idle instruction cycle
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_ff <= bbse_pkg::BBSE_ST_EXEC;
      end else begin
         case (state_ff)
            bbse_pkg::BBSE_ST_EXEC: begin
               if (live_ff && q4 && taken_ff) begin
                  state_ff <= bbse_pkg::BBSE_ST_NOP;
               end
            end
            bbse_pkg::BBSE_ST_NOP: begin
               if (q4) begin
                  state_ff <= bbse_pkg::BBSE_ST_EXEC;
               end
            end
            default: begin
               state_ff <= bbse_pkg::BBSE_ST_EXEC;
            end
         endcase
      end
   end

   // ==========================================================
   // Bit-set path: Q2 read, Q3 modify, Q4 write back
   // ==========================================================
   logic is_bsf;
   logic [DADDR_W-1:0] bsf_addr;
   assign is_bsf = live_ff && (op_ff == bbse_pkg::BBSE_OP_BSF);

   always_comb begin
      bsf_addr = file_addr(ir_ff[8], ir_ff[7:0], bank_ff);
   end

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         mod_ff <= 8'h00;
      end else if (is_bsf && ph_process) begin
         mod_ff <= mem.rdata | set_mask(ir_ff[11:9]);
      end
   end

   assign mem.rd_en = is_bsf && ph_read;
   assign mem.wr_en = is_bsf && ph_write;
   assign mem.addr = bsf_addr;
   assign mem.wdata = mod_ff;
   // No status flag outputs exist; only PC or memory changes
endmodule : bbse_top

// ### dv/bbse_top_sva.sv
/*
 Checker for the branch and bit-set execution block, bound to bbse_top.
 Assumes one phase per clock and the hand-over timing of the decoder.
*/
`timescale 1ns/1ps
module bbse_top_sva #(
   parameter int PC_W = 21,
   parameter int DADDR_W = 12
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic instr_req_in,
   input wire logic [15:0] instr_in,
   input wire logic [PC_W-1:0] pc_in,
   input wire logic zero_flag_in,
   input wire logic [3:0] bank_select_register_in,
   input wire logic instr_ack_out,
   input wire logic busy_out,
   input wire logic pc_load_out,
   input wire logic [PC_W-1:0] pc_next_out,
   input wire logic [1:0] phase_out,
   input wire logic unknown_op_out
);
   // ==========================================================
   // Decode helpers
   wire logic is_bnz = instr_ack_out && instr_in[15:8] == 8'hE1;
   wire logic is_bra = instr_ack_out && instr_in[15:11] == 5'h1A;
   wire logic is_bsf = instr_ack_out && instr_in[15:12] == 4'h8;
   wire logic [PC_W-1:0] bnz_tgt = pc_in + PC_W'(2) + {{(PC_W-9){instr_in[7]}}, instr_in[7:0], 1'b0};
   wire logic [PC_W-1:0] bra_tgt = pc_in + PC_W'(2) + {{(PC_W-12){instr_in[10]}}, instr_in[10:0], 1'b0};
   // ==========================================================
   // Properties
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   property p_bnz_tgt;
      logic [PC_W-1:0] t;
      (is_bnz && !zero_flag_in, t = bnz_tgt) |-> ##4 pc_load_out && pc_next_out == t;
   endproperty
   property p_bra_tgt;
      logic [PC_W-1:0] t;
      (is_bra, t = bra_tgt) |-> ##4 pc_load_out && pc_next_out == t;
   endproperty
   AST_ACK_PHASE: assert property (instr_ack_out |-> phase_out == 2'h0 && instr_req_in)
      else $error("acknowledge outside first phase");
   AST_BNZ_TARGET: assert property (p_bnz_tgt)
      else $error("not-zero branch target wrong");
   AST_BRA_TARGET: assert property (p_bra_tgt)
      else $error("unconditional branch target wrong");
   AST_BNZ_UNTAKEN: assert property (is_bnz && zero_flag_in |=> !pc_load_out [*4])
      else $error("untaken branch loaded the counter");
   AST_LOAD_PULSE: assert property (pc_load_out |=> !pc_load_out)
      else $error("counter load longer than one clock");
   AST_IDLE_CYCLE: assert property (pc_load_out |-> !instr_ack_out [*4])
      else $error("request taken during idle cycle");
   AST_IDLE_BUSY: assert property (pc_load_out |-> busy_out [*4])
      else $error("idle cycle not busy");
   AST_BSF_NO_LOAD: assert property (is_bsf |=> !pc_load_out [*5])
      else $error("bit-set loaded the counter");
   AST_BSF_KNOWN: assert property (is_bsf |=> !unknown_op_out)
      else $error("bit-set flagged as unknown");
   AST_LOAD_SOURCE: assert property ($rose(pc_load_out) |-> $past(phase_out) == 2'h3)
      else $error("counter load outside fourth phase");
   COV_BNZ: cover property (is_bnz && !zero_flag_in ##4 pc_load_out);
   COV_BRA: cover property (is_bra ##4 pc_load_out);
   COV_BSF: cover property (is_bsf && instr_in[8]);
endmodule : bbse_top_sva

bind bbse_top bbse_top_sva #(.PC_W(PC_W), .DADDR_W(DADDR_W)) u_sva (.core_clk_in(core_clk_in), .rst_in(rst_in),
   .instr_req_in(instr_req_in), .instr_in(instr_in), .pc_in(pc_in), .zero_flag_in(zero_flag_in),
   .bank_select_register_in(bank_select_register_in), .instr_ack_out(instr_ack_out), .busy_out(busy_out),
   .pc_load_out(pc_load_out), .pc_next_out(pc_next_out), .phase_out(phase_out), .unknown_op_out(unknown_op_out));

// ### dv/tb.sv
/*
 Self-checking bench for bbse_top: branches, bit-set and unknown opcodes.
 Assumes data memory inside the design is reachable as u_dut.u_ram.mem_ff.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; $display("FAIL t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb;
   localparam int PW = bbse_pkg::PC_W;
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic instr_req_in = 1'b0;
   logic [15:0] instr_in = 16'h0000;
   logic [PW-1:0] pc_in = '0;
   logic zero_flag_in = 1'b0;
   logic [3:0] bank_select_register_in = 4'h0;
   logic instr_ack_out, busy_out, pc_load_out, unknown_op_out;
   logic [PW-1:0] pc_next_out, exp_pc;
   logic [1:0] phase_out;
   logic [PW-1:0] exp_q[$];
   int failures = 0;
   int n_checks = 0;
   int cycles = 0;
   bit prev_jump = 1'b0;
   always #2.5 core_clk_in = ~core_clk_in;
   bbse_top u_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .instr_req_in(instr_req_in), .instr_in(instr_in),
      .pc_in(pc_in), .zero_flag_in(zero_flag_in), .bank_select_register_in(bank_select_register_in),
      .instr_ack_out(instr_ack_out), .busy_out(busy_out), .pc_load_out(pc_load_out), .pc_next_out(pc_next_out),
      .phase_out(phase_out), .unknown_op_out(unknown_op_out));
   // ==========================================================
   // Monitor and watchdog
   always @(posedge core_clk_in) begin
      #1;
      if (pc_load_out === 1'b1) begin
         if (exp_q.size() == 0) begin
            `CHK(pc_load_out, 1'b0)
         end else begin
            exp_pc = exp_q.pop_front();
            `CHK(pc_next_out, exp_pc)
         end
      end
   end
   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         final_report();
      end
   end
   // ==========================================================
   // Drivers
   task automatic issue(input logic [15:0] ins, input logic z, input logic [3:0] bank_select_register, input logic [PW-1:0] pc,
                        input logic unk, input bit jump, input logic [PW-1:0] tgt);
      int refused;
      refused = 0;
      do @(posedge core_clk_in); while (phase_out !== 2'h3);
      instr_in <= ins;
      zero_flag_in <= z;
      bank_select_register_in <= bank_select_register;
      pc_in <= pc;
      instr_req_in <= 1'b1;
      #1;
      while (instr_ack_out !== 1'b1 && refused < 3) begin
         refused++;
         do @(posedge core_clk_in); while (phase_out !== 2'h3);
         #1;
      end
      `CHK(refused, prev_jump ? 1 : 0)
      `CHK(busy_out, 1'b0)
      if (jump) exp_q.push_back(tgt);
      prev_jump = jump;
      @(posedge core_clk_in);
      instr_req_in <= 1'b0;
      @(posedge core_clk_in);
      #1;
      `CHK(unknown_op_out, unk)
      `CHK(busy_out, 1'b1)
      `CHK(phase_out, 2'h2)
   endtask : issue
   task automatic br(input bit wide, input int n, input logic z);
      logic [PW-1:0] pc;
      logic [15:0] ins;
      pc = PW'($urandom) & ~PW'(1);
      ins = wide ? {5'h1A, 11'(n)} : {8'hE1, 8'(n)};
      issue(ins, z, 4'($urandom), pc, 1'b0, wide | !z, pc + PW'(2) + PW'(2 * n));
   endtask : br
   task automatic set_file_bit_op(input int b, input logic a, input logic [7:0] f);
      logic [3:0] bank_select_register;
      logic [11:0] addr;
      logic [7:0] old;
      bank_select_register = 4'($urandom);
      addr = a ? {bank_select_register, f} : (f < 8'h80 ? {4'h0, f} : {4'hF, f});
      old = u_dut.u_ram.mem_ff[addr];
      issue({4'h8, 3'(b), a, f}, 1'($urandom), bank_select_register, PW'($urandom), 1'b0, 1'b0, '0);
      repeat (3) @(posedge core_clk_in);
      #1;
      `CHK(u_dut.u_ram.mem_ff[addr], old | (8'h01 << b))
   endtask : set_file_bit_op
   task automatic final_report;
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : final_report
   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(32'hCF92));
      repeat (3) @(posedge core_clk_in);
      rst_in <= 1'b0;
      br(1'b0, -128, 1'b0);
      br(1'b0, 127, 1'b0);
      br(1'b0, 5, 1'b1);
      br(1'b0, -7, 1'b1);
      for (int i = 0; i < 6; i++) br(1'b0, int'($urandom_range(255)) - 128, 1'($urandom));
      br(1'b1, -1024, 1'b0);
      br(1'b1, 1023, 1'b1);
      for (int i = 0; i < 4; i++) br(1'b1, int'($urandom_range(2047)) - 1024, 1'($urandom));
      for (int b = 0; b < 8; b++) set_file_bit_op(b, b >= 4, b == 0 ? 8'h7F : b == 1 ? 8'h80 : 8'($urandom));
      for (int b = 0; b < 16; b++) set_file_bit_op(b % 8, 1'b0, b < 8 ? 8'h10 : 8'h90);
      `CHK(u_dut.u_ram.mem_ff[12'h010], 8'hFF)
      `CHK(u_dut.u_ram.mem_ff[12'hF90], 8'hFF)
      issue(16'hE300, 1'b0, 4'h0, PW'(4), 1'b1, 1'b0, '0);
      issue(16'hFFFF, 1'b0, 4'h0, PW'(6), 1'b1, 1'b0, '0);
      br(1'b0, 3, 1'b0);
      repeat (12) @(posedge core_clk_in);
      `CHK(exp_q.size(), 0)
      final_report();
   end
endmodule : tb
